// *** align_ref_path.sv ***
/*
  alignment reference input path: pin synchroniser, polarity, receiver gate and event detector.
  assumes the reference pin is asynchronous to the system clock and far slower than it.
*/
`timescale 1ns/10ps
module align_ref_path (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  // pin and controls
  input wire logic i_align_ref,
  input wire logic i_receiver_en,
  input wire logic i_processor_en,
  input wire logic i_invert,
  // results
  output logic o_align_event,
  output logic o_ref_level
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic lvl;
    logic evt;
  } ref_state_s;
  ref_state_s q;
  ref_state_s n;

  always_comb begin
    n = q;
    n.s1 = i_align_ref;
    n.s2 = q.s1;
    n.lvl = i_receiver_en & (q.s2 ^ i_invert);
    n.evt = i_processor_en & n.lvl & ~q.lvl;
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign o_align_event = q.evt;
  assign o_ref_level = q.lvl;

  chk_invert_level: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    i_receiver_en |=> o_ref_level == ($past(q.s2) ^ $past(i_invert)))
    else $error("reference level does not follow polarity setting");
  chk_event_gated: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    o_align_event |-> $past(i_processor_en) && o_ref_level && !$past(o_ref_level))
    else $error("alignment event without processing enabled or edge");
endmodule // align_ref_path

// *** clock_ctrl_pkg.sv ***
/*
  constants, field positions and register layout for the clock control registers and their serial port.
  assumes nothing of its surroundings; the files that use it refer to it by package::name.
*/
package clock_ctrl_pkg;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int POS_W = 24;
  // register byte addresses
  localparam logic [14:0] ADDR_SYNC_REF_CONTROL = 15'h0029;
  localparam logic [14:0] ADDR_CLOCK_INPUT_MODE_CONTROL = 15'h002A;
  localparam logic [14:0] ADDR_SAMPLING_CLOCK_TUNING = 15'h002B;
  localparam logic [14:0] ADDR_POSITION_BYTE0 = 15'h002C;
  localparam logic [14:0] ADDR_POSITION_BYTE1 = 15'h002D;
  localparam logic [14:0] ADDR_POSITION_BYTE2 = 15'h002E;
  localparam logic [14:0] ADDR_STEP = 15'h0001;
  // reset values
  localparam logic [7:0] RST_SYNC_REF_CONTROL = 8'h00;
  localparam logic [7:0] RST_CLOCK_INPUT_MODE_CONTROL = 8'h00;
  localparam logic [7:0] RST_SAMPLING_CLOCK_TUNING = 8'h11;
  localparam logic [7:0] READ_IDLE = 8'h00;
  // field positions
  localparam int PROC_EN_BIT = 6;
  localparam int RECV_EN_BIT = 5;
  localparam int FINE_STEP_BIT = 4;
  localparam int DELAY_SEL_LSB = 0;
  localparam int DELAY_SEL_W = 4;
  localparam int MARKER_EN_BIT = 3;
  localparam int DEVCLK_PECL_BIT = 2;
  localparam int REF_PECL_BIT = 1;
  localparam int INVERT_BIT = 0;
  localparam int FB_GAIN_BIT = 4;
  localparam int NOISE_SUPP_BIT = 2;
  localparam int SCLK_DELAY_LSB = 0;
  localparam int SCLK_DELAY_W = 2;
  // serial frame
  localparam logic [4:0] HDR_BITS = 5'h10;
  localparam logic [4:0] DATA_BITS = 5'h08;
  localparam logic [4:0] CNT_STEP = 5'h01;
  localparam int PIN_SCLK = 0;
  localparam int PIN_SDI = 1;
  localparam int PIN_CS = 2;
  localparam logic [2:0] PIN_IDLE = 3'h4;
  typedef struct packed {
    logic [7:0] sync_ref_control;
    logic [7:0] clock_input_mode_control;
    logic [7:0] sampling_clock_tuning;
  } ctrl_regs_s;
endpackage

// *** reg_access_if.sv ***
/*
  byte access carrier between the serial port and the register file.
  assumes both ends run on the same system clock.
*/
`timescale 1ns/10ps
interface reg_access_if;
  logic wr;
  logic rd;
  logic [14:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport port (output wr, output rd, output addr, output wdata, input rdata);
  modport regs (input wr, input rd, input addr, input wdata, output rdata);
endinterface // reg_access_if

// *** spi_host_model.sv ***
/*
  host side of the serial register port: frames one access of a 16-bit header and whole data bytes, msb first.
  assumes sclk idles low and that each sclk phase of six system clocks meets the port's minimum.
*/
`timescale 1ns/10ps
module spi_host_model (
  // system clock
  input wire logic i_clk,
  // serial pins
  input wire logic i_sdo,
  output logic o_sclk,
  output logic o_sdi,
  output logic o_cs_b
);
  initial begin
    o_sclk = 1'b0;
    o_sdi = 1'b0;
    o_cs_b = 1'b1;
  end

  task automatic spi_half();
    repeat (6) @(negedge i_clk);
  endtask

  // first byte on the wire sits in the high bits of the low 8*n bits of wd and of rdat
  task automatic frame(input logic rd, input logic [14:0] addr, input int n, input logic [23:0] wd,
                       output logic [23:0] rdat);
    logic [15:0] hdr;
    int i;
    hdr = {rd, addr};
    rdat = '0;
    @(negedge i_clk);
    o_cs_b = 1'b0;
    spi_half();
    for (i = 0; i < 16 + 8 * n; i++) begin
      o_sdi = (i < 16) ? hdr[15 - i] : wd[8 * n - 1 - (i - 16)];
      spi_half();
      o_sclk = 1'b1;
      if (i >= 16) begin
        rdat = {rdat[22:0], i_sdo};
      end
      spi_half();
      o_sclk = 1'b0;
    end
    spi_half();
    o_cs_b = 1'b1;
    // released data line shows the inverse of its last value
    o_sdi = ~o_sdi;
    spi_half();
  endtask
endmodule // spi_host_model

// *** spi_reg_port.sv ***
/*
  serial register port: 16-bit header (read flag, 15-bit address) then streamed data bytes, msb first.
  assumes sclk idles low, is slower than one eighth of the system clock and that cs_b frames each access.
*/
`timescale 1ns/10ps
module spi_reg_port (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  // serial pins
  input wire logic i_spi_sclk,
  input wire logic i_spi_sdi,
  input wire logic i_spi_cs_b,
  output logic o_spi_sdo,
  // register side
  reg_access_if.port acc
);
  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] s3;
    logic [4:0] cnt;
    logic hdr_done;
    logic is_read;
    logic step;
    logic [15:0] sh;
    logic [14:0] addr;
    logic [7:0] osr;
    logic [7:0] wdata;
    logic sdo;
    logic rd;
  } spi_state_s;
  spi_state_s q;
  spi_state_s n;
  logic rise;
  logic fall;

  always_comb begin
    n = q;
    n.s1 = {i_spi_cs_b, i_spi_sdi, i_spi_sclk};
    n.s2 = q.s1;
    n.s3 = q.s2;
    n.step = 1'b0;
    n.rd = 1'b0;
    rise = q.s2[clock_ctrl_pkg::PIN_SCLK] & ~q.s3[clock_ctrl_pkg::PIN_SCLK];
    fall = ~q.s2[clock_ctrl_pkg::PIN_SCLK] & q.s3[clock_ctrl_pkg::PIN_SCLK];
    if (q.step) begin
      n.addr = q.addr + clock_ctrl_pkg::ADDR_STEP;
    end
    if (q.s2[clock_ctrl_pkg::PIN_CS]) begin
      n.cnt = '0;
      n.hdr_done = 1'b0;
    end else if (rise) begin
      n.sh = {q.sh[14:0], q.s2[clock_ctrl_pkg::PIN_SDI]};
      n.cnt = q.cnt + clock_ctrl_pkg::CNT_STEP;
      if (!q.hdr_done && q.cnt == clock_ctrl_pkg::HDR_BITS - clock_ctrl_pkg::CNT_STEP) begin
        n.hdr_done = 1'b1;
        n.is_read = q.sh[14];
        n.addr = {q.sh[13:0], q.s2[clock_ctrl_pkg::PIN_SDI]};
        n.cnt = '0;
      end else if (q.hdr_done && q.cnt == clock_ctrl_pkg::DATA_BITS - clock_ctrl_pkg::CNT_STEP) begin
        n.cnt = '0;
        n.step = 1'b1;
        n.wdata = {q.sh[6:0], q.s2[clock_ctrl_pkg::PIN_SDI]};
      end
    end else if (fall && q.hdr_done) begin
      if (q.cnt == '0) begin
        n.rd = q.is_read;
        n.sdo = acc.rdata[7];
        n.osr = {acc.rdata[6:0], 1'b0};
      end else begin
        n.sdo = q.osr[7];
        n.osr = {q.osr[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      q <= '{s1: clock_ctrl_pkg::PIN_IDLE, s2: clock_ctrl_pkg::PIN_IDLE, s3: clock_ctrl_pkg::PIN_IDLE, default: '0};
    end else begin
      q <= n;
    end
  end

  assign acc.wr = q.step & ~q.is_read;
  assign acc.rd = q.rd;
  assign acc.addr = q.addr;
  assign acc.wdata = q.wdata;
  assign o_spi_sdo = q.sdo;
endmodule // spi_reg_port

// *** sysref_clock_control_regs.sv ***
/*
  clock control register bank with its serial port and alignment reference path.
  assumes the position detector and marker enable come from logic on the system clock.
*/
`timescale 1ns/10ps
module sysref_clock_control_regs #(
  parameter int POS_W = clock_ctrl_pkg::POS_W
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  // serial register port
  input wire logic i_spi_sclk,
  input wire logic i_spi_sdi,
  input wire logic i_spi_cs_b,
  output logic o_spi_sdo,
  // alignment reference and status
  input wire logic i_align_ref,
  input wire logic i_sample_marker_enable,
  input wire logic [POS_W-1:0] i_capture_position,
  // sync ref controls
  output logic o_align_ref_receiver_enable,
  output logic o_align_ref_processor_enable,
  output logic o_window_fine_step,
  output logic [3:0] o_capture_delay_select,
  // input mode controls
  output logic o_align_ref_as_marker_enable,
  output logic o_device_clock_pecl_mode,
  output logic o_align_ref_pecl_mode,
  output logic o_align_ref_invert,
  // sampling clock tuning
  output logic o_clock_feedback_high_gain,
  output logic o_supply_noise_suppress,
  output logic [1:0] o_sample_clock_delay,
  // alignment results
  output logic o_align_event,
  output logic o_lsb_marker_select,
  output logic o_lsb_marker_bit
);
  generate
    if (POS_W != clock_ctrl_pkg::POS_W) begin : g_bad_pos_w
      $error("capture position width must be 24");
    end
  endgenerate

  typedef struct packed {
    clock_ctrl_pkg::ctrl_regs_s regs;
    logic marker_sel;
    logic marker_bit;
  } bank_state_s;

  localparam bank_state_s RESET_STATE = '{
    regs: '{
      sync_ref_control: clock_ctrl_pkg::RST_SYNC_REF_CONTROL,
      clock_input_mode_control: clock_ctrl_pkg::RST_CLOCK_INPUT_MODE_CONTROL,
      sampling_clock_tuning: clock_ctrl_pkg::RST_SAMPLING_CLOCK_TUNING
    },
    marker_sel: 1'b0,
    marker_bit: 1'b0
  };

  bank_state_s q;
  bank_state_s n;
  logic proc_effective;
  logic ref_level;

  reg_access_if acc ();

  spi_reg_port u_spi (
    .i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b),
    .i_spi_sclk(i_spi_sclk),
    .i_spi_sdi(i_spi_sdi),
    .i_spi_cs_b(i_spi_cs_b),
    .o_spi_sdo(o_spi_sdo),
    .acc(acc.port)
  );

  // true when a write strobe targets the given register
  function automatic logic wr_hit(input logic wr, input logic [14:0] addr, input logic [14:0] target);
    wr_hit = wr && (addr == target);
  endfunction

  // read data for any address; unmapped addresses read as zero
  function automatic logic [7:0] read_mux(
    input logic [14:0] addr,
    input clock_ctrl_pkg::ctrl_regs_s regs,
    input logic [POS_W-1:0] pos
  );
    read_mux = clock_ctrl_pkg::READ_IDLE;
    unique case (addr)
      clock_ctrl_pkg::ADDR_SYNC_REF_CONTROL: begin
        read_mux = regs.sync_ref_control;
      end
      clock_ctrl_pkg::ADDR_CLOCK_INPUT_MODE_CONTROL: begin
        read_mux = regs.clock_input_mode_control;
      end
      clock_ctrl_pkg::ADDR_SAMPLING_CLOCK_TUNING: begin
        read_mux = regs.sampling_clock_tuning;
      end
      clock_ctrl_pkg::ADDR_POSITION_BYTE0: begin
        read_mux = pos[7:0];
      end
      clock_ctrl_pkg::ADDR_POSITION_BYTE1: begin
        read_mux = pos[15:8];
      end
      clock_ctrl_pkg::ADDR_POSITION_BYTE2: begin
        read_mux = pos[23:16];
      end
      default: begin
        read_mux = clock_ctrl_pkg::READ_IDLE;
      end
    endcase
  endfunction

  // capture position is read straight from the detector, no side effects on read
  assign acc.rdata = read_mux(acc.addr, q.regs, i_capture_position);

  always_comb begin
    n = q;
    // whole bytes are stored, reserved bits included, except a tuning delay code that is not one-hot
    if (wr_hit(acc.wr, acc.addr, clock_ctrl_pkg::ADDR_SYNC_REF_CONTROL)) begin
      n.regs.sync_ref_control = acc.wdata;
    end
    if (wr_hit(acc.wr, acc.addr, clock_ctrl_pkg::ADDR_CLOCK_INPUT_MODE_CONTROL)) begin
      n.regs.clock_input_mode_control = acc.wdata;
    end
    if (wr_hit(acc.wr, acc.addr, clock_ctrl_pkg::ADDR_SAMPLING_CLOCK_TUNING)) begin
      n.regs.sampling_clock_tuning = acc.wdata;
      // a delay code that is not one-hot leaves the current delay in place
      if (!$onehot(acc.wdata[clock_ctrl_pkg::SCLK_DELAY_LSB +: clock_ctrl_pkg::SCLK_DELAY_W])) begin
        n.regs.sampling_clock_tuning[clock_ctrl_pkg::SCLK_DELAY_LSB +: clock_ctrl_pkg::SCLK_DELAY_W] =
          q.regs.sampling_clock_tuning[clock_ctrl_pkg::SCLK_DELAY_LSB +: clock_ctrl_pkg::SCLK_DELAY_W];
      end
    end
    n.marker_sel = q.regs.clock_input_mode_control[clock_ctrl_pkg::MARKER_EN_BIT] & i_sample_marker_enable;
    n.marker_bit = q.marker_sel & ref_level;
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      q <= RESET_STATE;
    end else begin
      q <= n;
    end
  end

  // event processing never runs with the receiver off, whatever order software used; o_align_ref_processor_enable is the register bit alone
  assign proc_effective = q.regs.sync_ref_control[clock_ctrl_pkg::PROC_EN_BIT]
    & q.regs.sync_ref_control[clock_ctrl_pkg::RECV_EN_BIT];

  align_ref_path u_ref (
    .i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b),
    .i_align_ref(i_align_ref),
    .i_receiver_en(q.regs.sync_ref_control[clock_ctrl_pkg::RECV_EN_BIT]),
    .i_processor_en(proc_effective),
    .i_invert(q.regs.clock_input_mode_control[clock_ctrl_pkg::INVERT_BIT]),
    .o_align_event(o_align_event),
    .o_ref_level(ref_level)
  );

  assign o_align_ref_receiver_enable = q.regs.sync_ref_control[clock_ctrl_pkg::RECV_EN_BIT];
  assign o_align_ref_processor_enable = q.regs.sync_ref_control[clock_ctrl_pkg::PROC_EN_BIT];
  assign o_window_fine_step = q.regs.sync_ref_control[clock_ctrl_pkg::FINE_STEP_BIT];
  assign o_capture_delay_select =
    q.regs.sync_ref_control[clock_ctrl_pkg::DELAY_SEL_LSB +: clock_ctrl_pkg::DELAY_SEL_W];
  assign o_align_ref_as_marker_enable = q.regs.clock_input_mode_control[clock_ctrl_pkg::MARKER_EN_BIT];
  assign o_device_clock_pecl_mode = q.regs.clock_input_mode_control[clock_ctrl_pkg::DEVCLK_PECL_BIT];
  assign o_align_ref_pecl_mode = q.regs.clock_input_mode_control[clock_ctrl_pkg::REF_PECL_BIT];
  assign o_align_ref_invert = q.regs.clock_input_mode_control[clock_ctrl_pkg::INVERT_BIT];
  assign o_clock_feedback_high_gain = q.regs.sampling_clock_tuning[clock_ctrl_pkg::FB_GAIN_BIT];
  assign o_supply_noise_suppress = q.regs.sampling_clock_tuning[clock_ctrl_pkg::NOISE_SUPP_BIT];
  assign o_sample_clock_delay =
    q.regs.sampling_clock_tuning[clock_ctrl_pkg::SCLK_DELAY_LSB +: clock_ctrl_pkg::SCLK_DELAY_W];
  assign o_lsb_marker_select = q.marker_sel;
  assign o_lsb_marker_bit = q.marker_bit;

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_b);

  sequence s_tuning_write;
    wr_hit(acc.wr, acc.addr, clock_ctrl_pkg::ADDR_SAMPLING_CLOCK_TUNING);
  endsequence

  sequence s_bad_delay_write;
    s_tuning_write ##0
      !$onehot(acc.wdata[clock_ctrl_pkg::SCLK_DELAY_LSB +: clock_ctrl_pkg::SCLK_DELAY_W]);
  endsequence

  sequence s_marker_both_on;
    q.regs.clock_input_mode_control[clock_ctrl_pkg::MARKER_EN_BIT] && i_sample_marker_enable;
  endsequence

  chk_reset_defaults: assert property (@(posedge i_clk_sys) disable iff (1'b0)
    !i_rst_b |=> o_clock_feedback_high_gain && o_sample_clock_delay == 2'h1 && !o_supply_noise_suppress)
    else $error("tuning register not at reset default");

  chk_receiver_reset: assert property (@(posedge i_clk_sys) disable iff (1'b0)
    !i_rst_b |=> !o_align_ref_receiver_enable && !o_align_ref_processor_enable && !o_align_event)
    else $error("receiver or processor enabled after reset");

  chk_delay_onehot: assert property (
    $onehot(o_sample_clock_delay))
    else $error("sample clock delay is not one-hot");

  chk_bad_delay_kept: assert property (
    s_bad_delay_write |=> $stable(o_sample_clock_delay)
      && o_clock_feedback_high_gain == $past(acc.wdata[clock_ctrl_pkg::FB_GAIN_BIT]))
    else $error("illegal delay code altered the delay or lost the rest");

  chk_reserved_store: assert property (
    s_tuning_write |=> q.regs.sampling_clock_tuning[7:5] == $past(acc.wdata[7:5])
      && q.regs.sampling_clock_tuning[3] == $past(acc.wdata[3]))
    else $error("reserved bits did not keep the written value");

  chk_select_write: assert property (
    wr_hit(acc.wr, acc.addr, clock_ctrl_pkg::ADDR_SYNC_REF_CONTROL)
      |=> o_capture_delay_select == $past(acc.wdata[3:0]) && o_window_fine_step == $past(acc.wdata[4]))
    else $error("capture delay select or fine step not updated by write");

  chk_mode_write: assert property (
    wr_hit(acc.wr, acc.addr, clock_ctrl_pkg::ADDR_CLOCK_INPUT_MODE_CONTROL)
      |=> o_device_clock_pecl_mode == $past(acc.wdata[2]) && o_align_ref_pecl_mode == $past(acc.wdata[1]))
    else $error("pecl mode bits not updated by write");

  chk_marker_gate: assert property (
    s_marker_both_on |=> o_lsb_marker_select)
    else $error("marker select missing with both enables set");

  chk_marker_off: assert property (
    !o_lsb_marker_select |=> !o_lsb_marker_bit)
    else $error("marker bit driven without marker select");

  chk_event_order: assert property (
    o_align_event |-> $past(o_align_ref_receiver_enable) && $past(o_align_ref_processor_enable))
    else $error("event passed without receiver and processor enabled");

  chk_position_read: assert property (
    acc.addr == clock_ctrl_pkg::ADDR_POSITION_BYTE2 |-> acc.rdata == i_capture_position[23:16])
    else $error("capture position byte mismatch");

  chk_unmapped_zero: assert property (
    acc.addr > clock_ctrl_pkg::ADDR_POSITION_BYTE2 |-> acc.rdata == clock_ctrl_pkg::READ_IDLE)
    else $error("unmapped address read nonzero");

  chk_noise_write: assert property (
    s_tuning_write |=> o_supply_noise_suppress == $past(acc.wdata[2]))
    else $error("noise suppression bit not updated by write");

  chk_invert_write: assert property (
    wr_hit(acc.wr, acc.addr, clock_ctrl_pkg::ADDR_CLOCK_INPUT_MODE_CONTROL)
      |=> o_align_ref_invert == $past(acc.wdata[0]))
    else $error("invert bit not updated by write");

  sequence s_ctrl0_write;
    wr_hit(acc.wr, acc.addr, clock_ctrl_pkg::ADDR_SYNC_REF_CONTROL);
  endsequence

  sequence s_mode_write;
    wr_hit(acc.wr, acc.addr, clock_ctrl_pkg::ADDR_CLOCK_INPUT_MODE_CONTROL);
  endsequence

  sequence s_good_delay_write;
    s_tuning_write ##0
      $onehot(acc.wdata[clock_ctrl_pkg::SCLK_DELAY_LSB +: clock_ctrl_pkg::SCLK_DELAY_W]);
  endsequence

  chk_enable_write: assert property (
    s_ctrl0_write |=> o_align_ref_receiver_enable == $past(acc.wdata[clock_ctrl_pkg::RECV_EN_BIT])
      && o_align_ref_processor_enable == $past(acc.wdata[clock_ctrl_pkg::PROC_EN_BIT]))
    else $error("receiver or processor enable not updated by write");

  chk_mode_reserved: assert property (
    s_mode_write |=> q.regs.clock_input_mode_control[7:4] == $past(acc.wdata[7:4])
      && o_align_ref_as_marker_enable == $past(acc.wdata[clock_ctrl_pkg::MARKER_EN_BIT]))
    else $error("mode register reserved or marker bit not stored");

  chk_delay_write: assert property (
    s_good_delay_write |=> o_sample_clock_delay == $past(acc.wdata[clock_ctrl_pkg::SCLK_DELAY_LSB +: clock_ctrl_pkg::SCLK_DELAY_W])
      && o_clock_feedback_high_gain == $past(acc.wdata[clock_ctrl_pkg::FB_GAIN_BIT]))
    else $error("legal delay code or feedback gain not stored");

  chk_regs_hold: assert property (
    !acc.wr |=> $stable(q.regs))
    else $error("register changed without a write");

  chk_marker_bit: assert property (
    o_lsb_marker_select && ref_level |=> o_lsb_marker_bit)
    else $error("marker bit does not carry the reference level");

  chk_position_low: assert property (
    acc.addr == clock_ctrl_pkg::ADDR_POSITION_BYTE0 |-> acc.rdata == i_capture_position[7:0])
    else $error("capture position low byte mismatch");

  chk_position_mid: assert property (
    acc.addr == clock_ctrl_pkg::ADDR_POSITION_BYTE1 |-> acc.rdata == i_capture_position[15:8])
    else $error("capture position middle byte mismatch");
endmodule // sysref_clock_control_regs

// *** tb_top.sv ***
/*
  self-checking bench for the clock control register bank, reached through its serial port.
  assumes the host model in spi_host_model.sv and the design package.
*/
`timescale 1ns/10ps
`define CHK(nm, exp, got) \
  num_checks++; \
  if ((got) !== (exp)) begin \
    mismatches++; \
    $display("[FAIL] %s expected %0h seen %0h", nm, exp, got); \
  end
module tb_top;
  logic i_clk_sys, i_rst_b, sclk, sdi, cs_b, sdo, i_align_ref, i_sample_marker_enable;
  logic [23:0] i_capture_position;
  logic recv, proc, fine, as_mark, dpecl, rpecl, inv, gain, noise, ev, msel, mbit;
  logic [3:0] dsel;
  logic [1:0] sdel;
  int mismatches = 0;
  int num_checks = 0;
  int cycles = 0;
  logic [23:0] rdat;
  int k, cnt;
  typedef struct packed {
    logic [14:0] addr;
    logic [7:0] wdata;
    logic [7:0] exp;
  } row_s;
  row_s rows[5] = '{
    '{15'h0029, 8'hA0, 8'hA0},
    '{15'h0029, 8'h7F, 8'h7F},
    '{15'h002A, 8'hFF, 8'hFF},
    '{15'h002B, 8'hEE, 8'hEE},
    '{15'h002B, 8'h03, 8'h02}
  };

  initial begin
    i_clk_sys = 1'b0;
    forever #12.5 i_clk_sys = ~i_clk_sys;
  end

  spi_host_model host (.i_clk(i_clk_sys), .i_sdo(sdo), .o_sclk(sclk), .o_sdi(sdi), .o_cs_b(cs_b));

  sysref_clock_control_regs #(.POS_W(24)) dut (
    .i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_spi_sclk(sclk), .i_spi_sdi(sdi), .i_spi_cs_b(cs_b),
    .o_spi_sdo(sdo), .i_align_ref(i_align_ref), .i_sample_marker_enable(i_sample_marker_enable),
    .i_capture_position(i_capture_position), .o_align_ref_receiver_enable(recv),
    .o_align_ref_processor_enable(proc), .o_window_fine_step(fine), .o_capture_delay_select(dsel),
    .o_align_ref_as_marker_enable(as_mark), .o_device_clock_pecl_mode(dpecl), .o_align_ref_pecl_mode(rpecl),
    .o_align_ref_invert(inv), .o_clock_feedback_high_gain(gain), .o_supply_noise_suppress(noise),
    .o_sample_clock_delay(sdel), .o_align_event(ev), .o_lsb_marker_select(msel), .o_lsb_marker_bit(mbit)
  );

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    forever begin
      @(posedge i_clk_sys);
      cycles++;
      if (cycles == 20000) begin
        mismatches++;
        stop_test();
      end
    end
  end

  task automatic wr(input logic [14:0] a, input int n, input logic [23:0] d);
    logic [23:0] dummy;
    host.frame(1'b0, a, n, d, dummy);
    repeat (10) @(negedge i_clk_sys);
  endtask

  task automatic rd(input logic [14:0] a, input int n, output logic [23:0] d);
    host.frame(1'b1, a, n, 24'h000000, d);
  endtask

  // sets the reference pin and counts event pulses over the following cycles
  task automatic pin_events(input logic v, output int c);
    c = 0;
    @(negedge i_clk_sys);
    i_align_ref = v;
    repeat (12) begin
      @(negedge i_clk_sys);
      if (ev !== 1'b0) begin
        c++;
      end
    end
  endtask

  initial begin
    i_rst_b = 1'b0;
    i_align_ref = 1'b0;
    i_sample_marker_enable = 1'b0;
    i_capture_position = 24'hC3A51E;
    repeat (10) @(negedge i_clk_sys);
    i_rst_b = 1'b1;
    repeat (6) @(negedge i_clk_sys);
    `CHK("gain", 1'b1, gain)
    `CHK("sdel", 2'h1, sdel)
    `CHK("recv", 1'b0, recv)
    rd(15'h0029, 3, rdat);
    `CHK("reset regs", 24'h000011, rdat)
    pin_events(1'b1, cnt);
    `CHK("events off", 0, cnt)
    for (k = 0; k < 5; k++) begin
      wr(rows[k].addr, 1, {16'h0000, rows[k].wdata});
      rd(rows[k].addr, 1, rdat);
      `CHK("readback", rows[k].exp, rdat[7:0])
      case (rows[k].addr)
        15'h0029: begin
          `CHK("ctrl0 outs", rows[k].exp & 8'h7F, {1'b0, proc, recv, fine, dsel})
        end
        15'h002A: begin
          `CHK("ctrl1 outs", rows[k].exp & 8'h0F, {4'h0, as_mark, dpecl, rpecl, inv})
        end
        default: begin
          `CHK("ctrl2 outs", rows[k].exp & 8'h17, {3'h0, gain, 1'b0, noise, sdel})
        end
      endcase
    end
    // processor enable without receiver enable: out of order on purpose
    wr(15'h0029, 1, 24'h000040);
    wr(15'h002A, 1, 24'h000000);
    pin_events(1'b0, cnt);
    pin_events(1'b1, cnt);
    `CHK("events recv off", 0, cnt)
    pin_events(1'b0, cnt);
    wr(15'h0029, 1, 24'h000020);
    wr(15'h0029, 1, 24'h000060);
    pin_events(1'b1, cnt);
    `CHK("event on", 1, cnt)
    wr(15'h002A, 1, 24'h000001);
    pin_events(1'b0, cnt);
    `CHK("inverted fall", 1, cnt)
    pin_events(1'b1, cnt);
    `CHK("inverted rise", 0, cnt)
    wr(15'h002A, 1, 24'h000008);
    i_sample_marker_enable = 1'b1;
    repeat (4) @(negedge i_clk_sys);
    `CHK("marker sel", 1'b1, msel)
    `CHK("marker bit", 1'b1, mbit)
    i_sample_marker_enable = 1'b0;
    repeat (4) @(negedge i_clk_sys);
    `CHK("marker sel off", 1'b0, msel)
    rd(15'h002C, 3, rdat);
    `CHK("position", 24'h1EA5C3, rdat)
    rd(15'h0030, 1, rdat);
    `CHK("unmapped", 8'h00, rdat[7:0])
    wr(15'h0029, 3, 24'h100011);
    rd(15'h0029, 3, rdat);
    `CHK("stream", 24'h100011, rdat)
    `CHK("fine", 1'b1, fine)
    // reset in mid-run brings every register back to its default
    @(negedge i_clk_sys);
    i_rst_b = 1'b0;
    repeat (10) @(negedge i_clk_sys);
    i_rst_b = 1'b1;
    repeat (6) @(negedge i_clk_sys);
    `CHK("mid reset gain", 1'b1, gain)
    `CHK("mid reset fine", 1'b0, fine)
    rd(15'h0029, 3, rdat);
    `CHK("mid reset regs", 24'h000011, rdat)
    stop_test();
  end
endmodule // tb_top
